// [hw/cfpm_params.svh]
// constants for the outbound frame source priority mux
`ifndef CFPM_PARAMS_SVH
`define CFPM_PARAMS_SVH

`define CFPM_WORD_W      32
`define CFPM_WIDX_W      4
`define CFPM_CWIDX_W     8
`define CFPM_WIDX_LAST   4'hF
`define CFPM_WIDX_CW     4'h0
`define CFPM_CW_COUNT    256
`define CFPM_CW_SYNC     8'h00
`define CFPM_CW_VER      8'h02
`define CFPM_K28_5       8'hBC
`define CFPM_D16_2       8'h50
`define CFPM_SYNC_WORD   32'h5050_50BC
`define CFPM_VER_MASK    32'h0000_00FF
`define CFPM_ALL_ONES    32'hFFFF_FFFF
`define CFPM_ZERO_WORD   32'h0000_0000

`endif

// [hw/cfpm_pkg.sv]
// types shared by the frame source priority mux
`default_nettype none
package cfpm_pkg;
	typedef logic [31:0] cfpm_word_t;
	typedef enum logic [3:0] {
		CFPM_SRC_NONE,
		CFPM_SRC_AUX,
		CFPM_SRC_RTVND,
		CFPM_SRC_VND,
		CFPM_SRC_CARRIER,
		CFPM_SRC_TABLE,
		CFPM_SRC_ETH,
		CFPM_SRC_HDLC,
		CFPM_SRC_L1,
		CFPM_SRC_REG,
		CFPM_SRC_SYMBOL,
		CFPM_SRC_DIRECT
	} cfpm_src_t;
endpackage
`default_nettype wire

// [hw/cfpm_mux.sv]
// outbound frame source priority mux and inbound frame router
//
// Summary of operation
// RL1: auxiliary word bus, delayed one slot, wins control-word bits it unmasks.
// RL2: bits aux leaves open come from realtime vendor, vendor, carrier control.
// RL3: open control-word bits then come from enabled control transmit table entry.
// RL4: a table entry not transmission-enabled contributes nothing to its position.
// RL5: remaining bits come from Ethernet, HDLC, then L1 status sources.
// RL6: lowest tier also places the protocol revision field at its position.
// RL7: lowest tier inserts comma and idle symbols into the sync position.
// RL8: delayed auxiliary word bus wins I/Q data bits it unmasks.
// RL9: I/Q bits aux leaves open come from the direct sample port.
// RL10: inbound control words and data are routed to matching user outputs.
// RL11: presence of each optional port is chosen by build parameter.
// RL12: link, transceiver and register ports are always built.
// RL13: same-tier conflicts resolve realtime vendor, vendor, carrier, then listed order.
`include "cfpm_params.svh"
`default_nettype none
module cfpm_mux #(
	parameter bit HAS_AUX  = 1'b1,	// auxiliary port built
	parameter bit HAS_RTV  = 1'b1,	// realtime vendor channel built
	parameter bit HAS_VND  = 1'b1,	// vendor channel built
	parameter bit HAS_CAR  = 1'b1,	// carrier control channel built
	parameter bit HAS_ETH  = 1'b1,	// fast control channel built
	parameter bit HAS_HDLC = 1'b1,	// slow control channel built
	parameter bit HAS_L1   = 1'b1,	// L1 status port built
	parameter bit HAS_DIQ  = 1'b1	// direct sample port built
) (
	input  wire logic             mclk,	// core clock
	input  wire logic             sys_rst,	// async reset, high
	input  wire logic             link_clk,	// link word clock from transceiver
	input  wire logic [31:0]      link_rx_data,	// inbound link word
	output var  logic [31:0]      link_tx_data_r,	// outbound link word
	output var  logic             link_tx_kchar_r,	// byte 0 is a comma symbol
	output var  logic [3:0]       slot_widx_r,	// word index to be filled next
	output var  logic [7:0]       slot_cwidx_r,	// control word index of frame
	output var  cfpm_pkg::cfpm_src_t tx_src_r,	// top source of last word
	input  wire logic [31:0]      aux_tx_data,	// auxiliary outbound word
	input  wire logic [31:0]      aux_tx_mask,	// auxiliary bit claim mask
	input  wire logic             rtv_valid,	// realtime vendor claims word
	input  wire logic [31:0]      rtv_data,	// realtime vendor word
	input  wire logic             vnd_valid,	// vendor claims word
	input  wire logic [31:0]      vnd_data,	// vendor word
	input  wire logic             car_valid,	// carrier control claims word
	input  wire logic [31:0]      car_data,	// carrier control word
	input  wire logic             tbl_wr,	// control table write strobe
	input  wire logic [7:0]       tbl_slot,	// control table slot pointer
	input  wire logic [31:0]      tbl_data,	// control table entry word
	input  wire logic             tbl_txen,	// entry transmission enable
	input  wire logic             eth_valid,	// Ethernet claims word
	input  wire logic [31:0]      eth_data,	// Ethernet word
	input  wire logic             hdlc_valid,	// HDLC claims word
	input  wire logic [31:0]      hdlc_data,	// HDLC word
	input  wire logic             l1_valid,	// L1 status claims word
	input  wire logic [31:0]      l1_data,	// L1 status word
	input  wire logic [7:0]       prot_ver_filter,	// protocol revision field
	input  wire logic [31:0]      diq_data,	// direct I/Q sample word
	output var  logic [31:0]      rx_aux_data_r,	// every inbound word
	output var  logic             rx_aux_valid_r,	// pulse per inbound word
	output var  logic [31:0]      rx_ctrl_data_r,	// inbound control word
	output var  logic [7:0]       rx_ctrl_idx_r,	// its control word index
	output var  logic             rx_ctrl_valid_r,	// pulse per control word
	output var  logic [31:0]      rx_iq_data_r,	// inbound I/Q word
	output var  logic             rx_iq_valid_r,	// pulse per I/Q word
	output var  logic [7:0]       rx_prot_ver_r,	// inbound protocol revision
	output var  logic             rx_ver_mismatch_r	// revision differs from filter
);

	// merge source bits into still-open bits, return {word, filled}
	function automatic logic [63:0] cfpm_merge(input logic [31:0] w, input logic [31:0] f,
		input logic [31:0] d, input logic [31:0] m);
		cfpm_merge = {w | (d & m & ~f), f | m};
	endfunction

	logic              lclk_s1_r;
	logic              lclk_s2_r;
	logic              lclk_s3_r;
	logic [31:0]       rxd_s1_r;
	logic [31:0]       rxd_s2_r;
	logic              slot;
	logic [31:0]       aux_d_r;
	logic [31:0]       aux_m_r;
	logic [31:0]       tbl_word_r [`CFPM_CW_COUNT];
	logic [255:0]      tbl_en_r;
	logic [31:0]       tx_nxt;
	logic [31:0]       fill;
	logic              kchar_nxt;
	cfpm_pkg::cfpm_src_t src_nxt;
	logic              is_cw;
	logic              aux_any;
	logic              sec_any;
	logic              low_any;

	// link clock and inbound word pass two flops before use
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			lclk_s1_r <= 1'b0;
			lclk_s2_r <= 1'b0;
			lclk_s3_r <= 1'b0;
			rxd_s1_r  <= `CFPM_ZERO_WORD;
			rxd_s2_r  <= `CFPM_ZERO_WORD;
		end else begin
			lclk_s1_r <= link_clk;
			lclk_s2_r <= lclk_s1_r;
			lclk_s3_r <= lclk_s2_r;
			rxd_s1_r  <= link_rx_data;
			rxd_s2_r  <= rxd_s1_r;
		end
	end

	assign slot = lclk_s2_r & ~lclk_s3_r;
	assign is_cw = (slot_widx_r == `CFPM_WIDX_CW);

	// word index advances once per link word, control word index once per 16-word frame
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			slot_widx_r  <= `CFPM_WIDX_CW;
			slot_cwidx_r <= `CFPM_CW_SYNC;
		end else if (slot) begin
			slot_widx_r <= slot_widx_r + 4'h1;
			if (slot_widx_r == `CFPM_WIDX_LAST) begin
				slot_cwidx_r <= slot_cwidx_r + 8'h01;
			end
		end
	end

	// auxiliary bus held one slot so it lines up with the next position
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			aux_d_r <= `CFPM_ZERO_WORD;
			aux_m_r <= `CFPM_ZERO_WORD;
		end else if (slot && HAS_AUX) begin // [RL11]
			aux_d_r <= aux_tx_data;
			aux_m_r <= aux_tx_mask;
		end
	end

	// control transmit table; latest write per slot wins
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			tbl_en_r <= '0;
			for (int i = 0; i < `CFPM_CW_COUNT; i++) begin
				tbl_word_r[i] <= `CFPM_ZERO_WORD;
			end
		end else if (tbl_wr) begin
			tbl_word_r[tbl_slot] <= tbl_data; // [RL3]
			tbl_en_r[tbl_slot]   <= tbl_txen; // [RL4]
		end
	end

	// claim summaries used by the checks only
	assign aux_any = HAS_AUX && (aux_m_r != `CFPM_ZERO_WORD);
	assign sec_any = (HAS_RTV && rtv_valid) || (HAS_VND && vnd_valid) || (HAS_CAR && car_valid);
	assign low_any = (HAS_ETH && eth_valid) || (HAS_HDLC && hdlc_valid) || (HAS_L1 && l1_valid);

	// per-bit fill, highest precedence first
	always_comb begin
		tx_nxt    = `CFPM_ZERO_WORD;
		fill      = `CFPM_ZERO_WORD;
		kchar_nxt = 1'b0;
		src_nxt   = cfpm_pkg::CFPM_SRC_NONE;
		if (HAS_AUX && aux_m_r != `CFPM_ZERO_WORD) begin
			{tx_nxt, fill} = cfpm_merge(tx_nxt, fill, aux_d_r, aux_m_r); // [RL1] [RL8]
			src_nxt = cfpm_pkg::CFPM_SRC_AUX;
		end
		if (is_cw) begin
			if (HAS_RTV && rtv_valid) begin
				{tx_nxt, fill} = cfpm_merge(tx_nxt, fill, rtv_data, `CFPM_ALL_ONES); // [RL2] [RL13]
				if (src_nxt == cfpm_pkg::CFPM_SRC_NONE) src_nxt = cfpm_pkg::CFPM_SRC_RTVND;
			end
			if (HAS_VND && vnd_valid) begin
				{tx_nxt, fill} = cfpm_merge(tx_nxt, fill, vnd_data, `CFPM_ALL_ONES); // [RL2] [RL13]
				if (src_nxt == cfpm_pkg::CFPM_SRC_NONE) src_nxt = cfpm_pkg::CFPM_SRC_VND;
			end
			if (HAS_CAR && car_valid) begin
				{tx_nxt, fill} = cfpm_merge(tx_nxt, fill, car_data, `CFPM_ALL_ONES); // [RL2] [RL13]
				if (src_nxt == cfpm_pkg::CFPM_SRC_NONE) src_nxt = cfpm_pkg::CFPM_SRC_CARRIER;
			end
			if (tbl_en_r[slot_cwidx_r]) begin
				{tx_nxt, fill} = cfpm_merge(tx_nxt, fill, tbl_word_r[slot_cwidx_r],
					`CFPM_ALL_ONES); // [RL3] [RL4]
				if (src_nxt == cfpm_pkg::CFPM_SRC_NONE) src_nxt = cfpm_pkg::CFPM_SRC_TABLE;
			end
			if (HAS_ETH && eth_valid) begin
				{tx_nxt, fill} = cfpm_merge(tx_nxt, fill, eth_data, `CFPM_ALL_ONES); // [RL5] [RL13]
				if (src_nxt == cfpm_pkg::CFPM_SRC_NONE) src_nxt = cfpm_pkg::CFPM_SRC_ETH;
			end
			if (HAS_HDLC && hdlc_valid) begin
				{tx_nxt, fill} = cfpm_merge(tx_nxt, fill, hdlc_data, `CFPM_ALL_ONES); // [RL5] [RL13]
				if (src_nxt == cfpm_pkg::CFPM_SRC_NONE) src_nxt = cfpm_pkg::CFPM_SRC_HDLC;
			end
			if (HAS_L1 && l1_valid) begin
				{tx_nxt, fill} = cfpm_merge(tx_nxt, fill, l1_data, `CFPM_ALL_ONES); // [RL5] [RL13]
				if (src_nxt == cfpm_pkg::CFPM_SRC_NONE) src_nxt = cfpm_pkg::CFPM_SRC_L1;
			end
			if (slot_cwidx_r == `CFPM_CW_VER) begin
				{tx_nxt, fill} = cfpm_merge(tx_nxt, fill, {24'h00_0000, prot_ver_filter},
					`CFPM_VER_MASK); // [RL6]
				if (src_nxt == cfpm_pkg::CFPM_SRC_NONE) src_nxt = cfpm_pkg::CFPM_SRC_REG;
			end
			if (slot_cwidx_r == `CFPM_CW_SYNC) begin
				kchar_nxt = (fill[7:0] == 8'h00); // [RL7]
				{tx_nxt, fill} = cfpm_merge(tx_nxt, fill, `CFPM_SYNC_WORD,
					`CFPM_ALL_ONES); // [RL7]
				if (src_nxt == cfpm_pkg::CFPM_SRC_NONE) src_nxt = cfpm_pkg::CFPM_SRC_SYMBOL;
			end
		end else if (HAS_DIQ) begin
			{tx_nxt, fill} = cfpm_merge(tx_nxt, fill, diq_data, `CFPM_ALL_ONES); // [RL9]
			if (src_nxt == cfpm_pkg::CFPM_SRC_NONE) src_nxt = cfpm_pkg::CFPM_SRC_DIRECT;
		end
	end

	// outbound word registered once per link slot
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			link_tx_data_r  <= `CFPM_ZERO_WORD;
			link_tx_kchar_r <= 1'b0;
			tx_src_r        <= cfpm_pkg::CFPM_SRC_NONE;
		end else if (slot) begin
			link_tx_data_r  <= tx_nxt; // [RL12]
			link_tx_kchar_r <= kchar_nxt;
			tx_src_r        <= src_nxt;
		end
	end

	// inbound router: split control and I/Q words per position
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_aux_data_r     <= `CFPM_ZERO_WORD;
			rx_aux_valid_r    <= 1'b0;
			rx_ctrl_data_r    <= `CFPM_ZERO_WORD;
			rx_ctrl_idx_r     <= `CFPM_CW_SYNC;
			rx_ctrl_valid_r   <= 1'b0;
			rx_iq_data_r      <= `CFPM_ZERO_WORD;
			rx_iq_valid_r     <= 1'b0;
			rx_prot_ver_r     <= 8'h00;
			rx_ver_mismatch_r <= 1'b0;
		end else begin
			rx_aux_valid_r  <= slot && HAS_AUX; // [RL10]
			rx_ctrl_valid_r <= slot && is_cw; // [RL10]
			rx_iq_valid_r   <= slot && !is_cw && HAS_DIQ; // [RL10]
			if (slot) begin
				rx_aux_data_r <= rxd_s2_r;
				if (is_cw) begin
					rx_ctrl_data_r <= rxd_s2_r;
					rx_ctrl_idx_r  <= slot_cwidx_r;
					if (slot_cwidx_r == `CFPM_CW_VER) begin
						rx_prot_ver_r     <= rxd_s2_r[7:0];
						rx_ver_mismatch_r <= (rxd_s2_r[7:0] != prot_ver_filter);
					end
				end else begin
					rx_iq_data_r <= rxd_s2_r;
				end
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	chk_aux_ctrl_first: assert property ( // [RL1]
		slot && is_cw && HAS_AUX && aux_m_r == `CFPM_ALL_ONES
		|=> link_tx_data_r == $past(aux_d_r))
		else $error("aux word did not win control position");
	chk_rt_vendor_fill: assert property ( // [RL2]
		slot && is_cw && !aux_any && HAS_RTV && rtv_valid
		|=> link_tx_data_r == $past(rtv_data) && tx_src_r == cfpm_pkg::CFPM_SRC_RTVND)
		else $error("realtime vendor word not sent");
	chk_vendor_order: assert property ( // [RL13]
		slot && is_cw && !aux_any && !(HAS_RTV && rtv_valid) && HAS_VND && vnd_valid
		|=> link_tx_data_r == $past(vnd_data))
		else $error("vendor word not sent ahead of lower sources");
	chk_table_fill: assert property ( // [RL3]
		slot && is_cw && !aux_any && !sec_any && tbl_en_r[slot_cwidx_r]
		|=> link_tx_data_r == $past(tbl_word_r[slot_cwidx_r]))
		else $error("enabled table entry not sent");
	chk_table_blocked: assert property ( // [RL4]
		slot && is_cw && !aux_any && !sec_any && !low_any && !tbl_en_r[slot_cwidx_r]
		&& slot_cwidx_r != `CFPM_CW_SYNC && slot_cwidx_r != `CFPM_CW_VER
		|=> link_tx_data_r == `CFPM_ZERO_WORD
		&& tx_src_r == cfpm_pkg::CFPM_SRC_NONE)
		else $error("disabled table entry leaked");
	chk_eth_fill: assert property ( // [RL5]
		slot && is_cw && !aux_any && !sec_any && !tbl_en_r[slot_cwidx_r] && HAS_ETH && eth_valid
		|=> link_tx_data_r == $past(eth_data))
		else $error("ethernet word not sent");
	chk_ver_field: assert property ( // [RL6]
		slot && is_cw && slot_cwidx_r == `CFPM_CW_VER && !aux_any && !sec_any && !low_any
		&& !tbl_en_r[slot_cwidx_r]
		|=> link_tx_data_r[7:0] == $past(prot_ver_filter))
		else $error("revision field not placed");
	chk_sync_symbol: assert property ( // [RL7]
		slot && is_cw && slot_cwidx_r == `CFPM_CW_SYNC && !aux_any && !sec_any && !low_any
		&& !tbl_en_r[slot_cwidx_r]
		|=> link_tx_data_r == `CFPM_SYNC_WORD && link_tx_kchar_r)
		else $error("sync symbols not inserted");
	chk_aux_iq_first: assert property ( // [RL8]
		slot && !is_cw && HAS_AUX && aux_m_r == `CFPM_ALL_ONES
		|=> link_tx_data_r == $past(aux_d_r))
		else $error("aux word did not win I/Q position");
	chk_direct_iq: assert property ( // [RL9]
		slot && !is_cw && !aux_any && HAS_DIQ
		|=> link_tx_data_r == $past(diq_data) && tx_src_r == cfpm_pkg::CFPM_SRC_DIRECT)
		else $error("direct sample word not sent");
	chk_rx_ctrl_route: assert property ( // [RL10]
		slot && is_cw
		|=> rx_ctrl_valid_r && rx_ctrl_data_r == $past(rxd_s2_r)
		##1 !rx_ctrl_valid_r)
		else $error("inbound control word not routed");

endmodule
`default_nettype wire

// [verification/cfpm_peer.sv]
// peer link node model: word clock and inbound words for the mux
`default_nettype none
module cfpm_peer (
	output var  logic        link_clk,	// free running word clock
	output var  logic [31:0] link_rx_data,	// inbound word toward the mux
	input  wire logic [31:0] rx_next	// word to send on the next slot
);
	timeunit 1ns;
	timeprecision 1ns;
	// word clock, 800 ns, edges kept off the core clock edges
	// each word launches half a period before its rising edge, the first one too
	initial begin
		link_clk     = 1'b0;
		link_rx_data = 32'h0000_0000;
		#825;
		forever begin
			link_rx_data <= rx_next;
			#400;
			link_clk = 1'b1;
			#400;
			link_clk = 1'b0;
		end
	end
endmodule
`default_nettype wire

// [verification/cfpm_frame_source_priority_mux_tb.sv]
// self-checking bench for the outbound source priority mux and inbound router
`default_nettype none
module cfpm_frame_source_priority_mux_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0, sys_rst = 1'b1, link_clk, tbl_wr = 1'b0, tbl_txen = 1'b0;
	logic [31:0] link_rx_data, rx_next, link_tx_data_r, aux_tx_mask = 32'h0;
	logic link_tx_kchar_r, rtv_valid = 0, vnd_valid = 0, car_valid = 0;
	logic eth_valid = 0, hdlc_valid = 0, l1_valid = 0;
	logic [3:0] slot_widx_r;
	logic [7:0] slot_cwidx_r, tbl_slot = 8'h00, rx_ctrl_idx_r, rx_prot_ver_r;
	logic [7:0] prot_ver_filter = 8'h07;
	logic [31:0] tbl_data = 32'h0, rx_aux_data_r, rx_ctrl_data_r, rx_iq_data_r;
	logic [31:0] diq_data = 32'h9999_8888;
	logic rx_aux_valid_r, rx_ctrl_valid_r, rx_iq_valid_r, rx_ver_mismatch_r;
	cfpm_pkg::cfpm_src_t tx_src_r;
	int n_errors = 0, tests_run = 0, cyc = 0;
	logic [31:0] aux_tx_data = 32'h1234_ABCD, rtv_data = 32'h1111_0001;
	logic [31:0] vnd_data = 32'h2222_0002;
	// core clock, 100 ns
	always #50 mclk = ~mclk;
	cfpm_peer cfpm_peer_inst (.link_clk(link_clk), .link_rx_data(link_rx_data),
		.rx_next(rx_next));
	cfpm_mux cfpm_mux_inst (.mclk(mclk), .sys_rst(sys_rst), .link_clk(link_clk),
		.link_rx_data(link_rx_data), .link_tx_data_r(link_tx_data_r),
		.link_tx_kchar_r(link_tx_kchar_r), .slot_widx_r(slot_widx_r),
		.slot_cwidx_r(slot_cwidx_r), .tx_src_r(tx_src_r), .aux_tx_data(aux_tx_data),
		.aux_tx_mask(aux_tx_mask), .rtv_valid(rtv_valid), .rtv_data(rtv_data),
		.vnd_valid(vnd_valid), .vnd_data(vnd_data), .car_valid(car_valid),
		.car_data(32'h3333_0003), .tbl_wr(tbl_wr), .tbl_slot(tbl_slot),
		.tbl_data(tbl_data), .tbl_txen(tbl_txen), .eth_valid(eth_valid),
		.eth_data(32'h4444_0004), .hdlc_valid(hdlc_valid), .hdlc_data(32'h5555_0005),
		.l1_valid(l1_valid), .l1_data(32'h6666_0006), .prot_ver_filter(prot_ver_filter),
		.diq_data(diq_data), .rx_aux_data_r(rx_aux_data_r),
		.rx_aux_valid_r(rx_aux_valid_r), .rx_ctrl_data_r(rx_ctrl_data_r),
		.rx_ctrl_idx_r(rx_ctrl_idx_r), .rx_ctrl_valid_r(rx_ctrl_valid_r),
		.rx_iq_data_r(rx_iq_data_r), .rx_iq_valid_r(rx_iq_valid_r),
		.rx_prot_ver_r(rx_prot_ver_r), .rx_ver_mismatch_r(rx_ver_mismatch_r));
	// word compare
	task automatic chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// source code compare
	task automatic chk_s(input cfpm_pkg::cfpm_src_t e, input cfpm_pkg::cfpm_src_t g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("BAD tx_src_r expected %0d seen %0d", e, g);
		end
	endtask
	// wait at falling edges until the counters point at a position
	task automatic goto_pos(input logic [3:0] w, input logic [7:0] cw);
		int i;
		for (i = 0; i < 4000 && !(slot_widx_r === w && slot_cwidx_r === cw); i++)
			@(negedge mclk);
	endtask
	// wait until the next slot edge has landed
	task automatic wait_slot;
		logic [3:0] w0;
		int i;
		w0 = slot_widx_r;
		for (i = 0; i < 20 && slot_widx_r === w0; i++) @(negedge mclk);
	endtask
	// control table write, one strobe cycle
	task automatic tbl_put(input logic [7:0] s, input logic [31:0] d, input logic en);
		@(negedge mclk);
		{tbl_wr, tbl_slot, tbl_data, tbl_txen} = {1'b1, s, d, en};
		@(negedge mclk);
		tbl_wr = 1'b0;
	endtask
	// fill one position: aux mask goes in one slot early, then check both paths
	task automatic slot_run(input logic [3:0] w, input logic [7:0] cw, input logic [31:0] am,
		input logic [31:0] e, input cfpm_pkg::cfpm_src_t es, input logic ek);
		logic [31:0] rxw;
		rxw = {16'hA5C3, 4'h0, w, cw};
		if (am != 32'h0) begin
			goto_pos(w - 4'h1, (w == 4'h0) ? cw - 8'h01 : cw);
			aux_tx_mask = am;
			wait_slot();
			aux_tx_mask = 32'h0;
		end
		goto_pos(w, cw);
		rx_next = rxw;
		wait_slot();
		chk_w("link_tx_data_r", e, link_tx_data_r);
		chk_s(es, tx_src_r);
		chk_w("link_tx_kchar_r", {31'h0, ek}, {31'h0, link_tx_kchar_r});
		chk_w("rx_aux_data_r", rxw, rx_aux_data_r);
		chk_w("rx_aux_valid_r", 32'h1, {31'h0, rx_aux_valid_r});
		if (w == 4'h0) begin
			chk_w("rx_ctrl_data_r", rxw, rx_ctrl_data_r);
			chk_w("rx_ctrl_idx", {24'h0, cw}, {24'h0, rx_ctrl_idx_r});
			chk_w("rx_ctrl_valid_r", 32'h1, {31'h0, rx_ctrl_valid_r});
		end else begin
			chk_w("rx_iq_data_r", rxw, rx_iq_data_r);
			chk_w("rx_iq_valid_r", 32'h1, {31'h0, rx_iq_valid_r});
		end
		$display("test word %0d control %0d finished", w, cw);
	endtask
	// verdict and end of run
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// cut a hang short
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			end_sim();
		end
	end
	// main sequence
	initial begin
		rx_next = 32'hA5C3_0000;
		repeat (6) @(negedge mclk);
		sys_rst = 1'b0;
		@(negedge mclk);
		chk_w("link_tx_data_r reset", 32'h0, link_tx_data_r);
		chk_s(cfpm_pkg::CFPM_SRC_NONE, tx_src_r);
		tbl_put(8'h04, 32'h7777_0004, 1'b1);
		tbl_put(8'h05, 32'h7777_0005, 1'b1);
		tbl_put(8'h05, 32'h7777_0F05, 1'b0);
		slot_run(4'h0, 8'h00, 32'h0, 32'h5050_50BC, cfpm_pkg::CFPM_SRC_SYMBOL, 1'b1);
		{rtv_valid, vnd_valid, car_valid, eth_valid} = 4'hF;
		slot_run(4'h0, 8'h01, 32'h0, 32'h1111_0001, cfpm_pkg::CFPM_SRC_RTVND, 1'b0);
		{rtv_valid, vnd_valid, car_valid, eth_valid} = 4'h0;
		slot_run(4'h0, 8'h02, 32'h0, 32'h0000_0007, cfpm_pkg::CFPM_SRC_REG, 1'b0);
		chk_w("rx_prot_ver_r", 32'h02, {24'h0, rx_prot_ver_r});
		chk_w("rx_ver_mismatch_r", 32'h1, {31'h0, rx_ver_mismatch_r});
		{car_valid, eth_valid, hdlc_valid} = 3'h7;
		slot_run(4'h0, 8'h03, 32'h0, 32'h3333_0003, cfpm_pkg::CFPM_SRC_CARRIER, 1'b0);
		{car_valid, hdlc_valid} = 2'h0;
		slot_run(4'h0, 8'h04, 32'h0, 32'h7777_0004, cfpm_pkg::CFPM_SRC_TABLE, 1'b0);
		slot_run(4'h0, 8'h05, 32'h0, 32'h4444_0004, cfpm_pkg::CFPM_SRC_ETH, 1'b0);
		{eth_valid, hdlc_valid, l1_valid} = 3'h3;
		slot_run(4'h0, 8'h06, 32'h0, 32'h5555_0005, cfpm_pkg::CFPM_SRC_HDLC, 1'b0);
		hdlc_valid = 1'b0;
		slot_run(4'h0, 8'h07, 32'h0, 32'h6666_0006, cfpm_pkg::CFPM_SRC_L1, 1'b0);
		l1_valid = 1'b0;
		slot_run(4'h3, 8'h08, 32'h00FF_00FF, 32'h9934_88CD, cfpm_pkg::CFPM_SRC_AUX, 1'b0);
		rtv_valid = 1'b1;
		slot_run(4'h4, 8'h08, 32'h0, 32'h9999_8888, cfpm_pkg::CFPM_SRC_DIRECT, 1'b0);
		rtv_valid = 1'b0;
		{vnd_valid, car_valid} = 2'h3;
		slot_run(4'h0, 8'h09, 32'h0, 32'h2222_0002, cfpm_pkg::CFPM_SRC_VND, 1'b0);
		{vnd_valid, car_valid} = 2'h0;
		slot_run(4'h5, 8'h09, 32'hFFFF_FFFF, 32'h1234_ABCD, cfpm_pkg::CFPM_SRC_AUX, 1'b0);
		rtv_valid = 1'b1;
		slot_run(4'h0, 8'h0A, 32'hFFFF_0000, 32'h1234_0001, cfpm_pkg::CFPM_SRC_AUX, 1'b0);
		slot_run(4'h0, 8'h0B, 32'hFFFF_FFFF, 32'h1234_ABCD, cfpm_pkg::CFPM_SRC_AUX, 1'b0);
		rtv_valid = 1'b0;
		end_sim();
	end
endmodule
`default_nettype wire
